// ### dv/fabric_model.sv
/*
  Fabric-side model that shapes video syncs, fields and sleep pulses.
  Assumes the bench feeds a fresh random word on rnd_i every cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module fabric_model
  import csi_tx_pkg::*;
(
  // Clock.
  input wire logic clock_i,
  // Random word from the bench.
  input wire logic [63:0] rnd_i,
  // Toward the port.
  output var video_in_t video_o,
  output var sleep_req_t sleep_o
);
  logic fs_q = 1'b0;
  logic ls_q = 1'b0;
  logic vl_q = 1'b0;
  logic [15:0] width_q = '0;
  logic [5:0] type_q = '0;
  logic [1:0] chan_q = '0;
  initial sleep_o = '0;
  assign video_o = '{fs_q, ls_q, vl_q, width_q, type_q, chan_q, rnd_i};

  task automatic frame(input logic [15:0] w, input logic [5:0] t,
                       input logic [1:0] v, input int lines,
                       input int len);
    // fields change outside frame, held before rise.
    @(posedge clock_i);
    width_q <= w;
    chan_q <= v;
    @(posedge clock_i);
    fs_q <= 1'b1;
    for (int i = 0; i < lines; i++) begin
      // type changes outside line, held before rise.
      @(posedge clock_i);
      type_q <= t + 6'(i);
      @(posedge clock_i);
      ls_q <= 1'b1;
      repeat (len) begin
        @(posedge clock_i);
        vl_q <= rnd_i[0];
      end
      @(posedge clock_i);
      vl_q <= 1'b0;
      ls_q <= 1'b0;
    end
    @(posedge clock_i);
    fs_q <= 1'b0;
  endtask : frame

  // one request at a time, short only when the bench asks.
  task automatic pulse(input sleep_req_t r, input int n);
    @(posedge clock_i);
    sleep_o <= r;
    repeat (n) @(posedge clock_i);
    sleep_o <= '0;
  endtask : pulse
endmodule : fabric_model
`default_nettype wire

// ### dv/testbench.sv
/*
  Self-checking bench for the pixel input port: bus accesses, strap
  decoding, video capture against a reference model and lane sleep.
  Assumes the fabric model drives video and sleep requests.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench
  import csi_tx_pkg::*;
;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic hready;
  logic hresp;
  logic [31:0] hrdata;
  logic ff = 1'b0;
  logic [1:0] lc = LANES_FOUR;
  logic [31:0] seed = 32'h977e;
  logic [63:0] rnd = '0;
  video_in_t vid;
  sleep_req_t slp;
  tx_word_t txw;
  tx_word_t m_w;
  logic txv;
  logic m_v;
  logic m_fs;
  logic m_ls;
  logic [15:0] m_cnt;
  logic [4:0] pos;
  logic [4:0] neg;
  logic [4:0] m_sleep = '0;
  logic [1:0] m_pad;
  logic chk_lane = 1'b0;
  logic last_ck = 1'b0;
  int n_mismatch = 0;
  int samples_checked = 0;

  always #12.5 clock_i = ~clock_i;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  always @(posedge clock_i) begin
    seed <= xs(xs(seed));
    rnd <= {seed, xs(seed)};
  end

  csi_tx_pixel_port u_dut (
    .clock_i(clock_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready),
    .hresp_o(hresp), .hrdata_o(hrdata), .video_i(vid),
    .frame_format_i(ff), .lane_count_i(lc), .sleep_i(slp),
    .tx_word_o(txw), .tx_valid_o(txv), .lane_pos_pads_o(pos),
    .lane_neg_pads_o(neg));

  fabric_model u_fab (
    .clock_i(clock_i), .rnd_i(rnd), .video_o(vid), .sleep_o(slp));

  // Reference model of the captured word, built from the stimulus.
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      m_w <= '0;
      m_v <= 1'b0;
      m_fs <= 1'b0;
      m_ls <= 1'b0;
      m_cnt <= '0;
      m_pad <= 2'h3;
    end else begin
      m_v <= vid.valid;
      m_pad <= (m_ls && m_v) ? {m_w.data[0], ~m_w.data[0]} : 2'h3;
      m_fs <= vid.frame_sync;
      m_ls <= vid.line_sync;
      if (vid.valid) m_w.data <= vid.data;
      if (vid.frame_sync && !m_fs) begin
        m_w.line_width_pixels <= vid.line_width_pixels;
        m_w.virtual_channel_id <= vid.virtual_channel_id;
      end
      if (vid.line_sync && !m_ls) m_w.data_type <= vid.data_type;
      if (vid.line_sync && !m_ls) m_cnt <= {15'h0, vid.valid};
      else if (vid.valid) m_cnt <= m_cnt + 16'h1;
    end
  end

  task automatic print_verdict();
    $display("compared %0d mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  task automatic chk_reg(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_reg

  task automatic chk_vid(input string nm, input tx_word_t e,
                         input tx_word_t g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_vid

  task automatic chk_pad(input string nm, input logic [1:0] e,
                         input logic [1:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_pad

  always @(negedge clock_i) begin
    if (!rst_i) begin
      chk_vid("tx_word", m_w, txw);
      chk_reg("tx_valid", {31'h0, m_v}, {31'h0, txv});
      if (chk_lane) begin
        chk_pad("data pads", m_pad, {pos[0], neg[0]});
        chk_pad("clock pads", {~last_ck, last_ck}, {pos[2], neg[2]});
      end
    end
    last_ck = pos[2];
  end

  // The slave may stretch a phase, so every wait is bounded.
  task automatic wait_ready();
    int k;
    k = 0;
    do begin
      @(posedge clock_i);
      k++;
    end while (hready !== 1'b1 && k < 64);
    if (hready !== 1'b1) begin
      n_mismatch++;
      print_verdict();
    end
  endtask : wait_ready

  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clock_i);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    chk_reg("hresp", 32'h0, {31'h0, hresp});
  endtask : ahb

  function automatic sleep_req_t req(input logic [2:0] r,
                                     input logic lv);
    sleep_req_t q;
    q = '0;
    q.clock_lane_sleep_enter = (r == ROLE_CLK) && !lv;
    q.clock_lane_sleep_leave = (r == ROLE_CLK) && lv;
    if (r != ROLE_CLK && lv) q.data_lane_sleep_leave[2'(r - 3'h1)] = 1'b1;
    if (r != ROLE_CLK && !lv) q.data_lane_sleep_enter[2'(r - 3'h1)] = 1'b1;
    return q;
  endfunction : req

  task automatic reset(input logic f, input logic [1:0] l);
    @(posedge clock_i);
    rst_i <= 1'b1;
    ff <= f;
    lc <= l;
    m_sleep = '0;
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
  endtask : reset

  initial begin
    logic [31:0] d;
    logic [31:0] e;
    logic [31:0] cfg;
    logic [2:0] r;
    for (int i = 0; i < 3; i++) begin
      reset(i[0], (i == 2) ? LANES_FOUR : 2'(i));
      ahb(1'b0, 32'h0c, '0, d);
      chk_reg("status", {24'h0, lc, ff, 5'h0}, d);
      @(negedge clock_i);
      for (int p = 0; p < 5; p++)
        if (LANE_MAP[p] != ROLE_CLK)
          chk_pad("pads", (int'(LANE_MAP[p]) <= (1 << i)) ? 2'h3 : 2'h0,
                  {pos[p], neg[p]});
    end
    cfg = {3'h0, CONT_CLOCK, REF_CLK_TABLE[REF_CLK_SEL], PHY_RATE_SEL};
    ahb(1'b0, 32'h00, '0, d);
    chk_reg("config", cfg, d);
    ahb(1'b0, 32'h04, '0, d);
    chk_reg("clk_tim", CLK_TIM_RST, d);
    ahb(1'b0, 32'h08, '0, d);
    chk_reg("dat_tim", DAT_TIM_RST, d);
    for (int i = 0; i < 3; i++) begin
      e = rnd[31:0];
      ahb(1'b1, 32'h04, e, d);
      ahb(1'b1, 32'h08, e, d);
      ahb(1'b1, 32'h00, e, d);
      ahb(1'b1, 32'h18, e, d);
      ahb(1'b0, 32'h04, '0, d);
      chk_reg("clk_tim", e, d);
      ahb(1'b0, 32'h08, '0, d);
      chk_reg("dat_tim", {8'h0, e[23:0]}, d);
      ahb(1'b0, 32'h00, '0, d);
      chk_reg("config", cfg, d);
      ahb(1'b0, 32'h18, '0, d);
      chk_reg("unmapped", 32'h0, d);
    end
    chk_lane = 1'b1;
    for (int f = 0; f < 3; f++) begin
      u_fab.frame(rnd[15:0], 6'h20 + 6'(f), rnd[17:16], 2, 1 + 6 * f);
      ahb(1'b0, 32'h10, '0, d);
      chk_reg("line", {8'h0, m_w.virtual_channel_id, m_w.data_type,
              m_w.line_width_pixels}, d);
      ahb(1'b0, 32'h14, '0, d);
      chk_reg("words", {16'h0, m_cnt}, d);
    end
    chk_lane = 1'b0;
    for (int p = 0; p < 5; p++) begin
      r = LANE_MAP[p];
      u_fab.pulse(req(r, 1'b0), ULPS_MIN_CYC);
      m_sleep[r] = 1'b1;
      ahb(1'b0, 32'h0c, '0, d);
      chk_reg("status", {24'h0, lc, ff, m_sleep}, d);
      @(negedge clock_i);
      chk_pad("sleep pads", 2'h0, {pos[p], neg[p]});
      u_fab.pulse(req(r, 1'b1), ULPS_MIN_CYC - 1);
      ahb(1'b0, 32'h0c, '0, d);
      chk_reg("status", {24'h0, lc, ff, m_sleep}, d);
      u_fab.pulse(req(r, 1'b1), ULPS_MIN_CYC);
      m_sleep[r] = 1'b0;
      ahb(1'b0, 32'h0c, '0, d);
      chk_reg("status", {24'h0, lc, ff, m_sleep}, d);
    end
    print_verdict();
  end
endmodule : testbench
`default_nettype wire

// ### rtl/csi_tx_pixel_port.sv
/*
  Pixel input port of the camera transmitter: takes video words and
  sync levels from fabric logic, keeps per-lane sleep state, drives
  the lane pads at low-power or high-speed levels and serves an AHB-Lite register
  file for build options, lane timing and status.
  Assumes all video and sleep inputs come from logic on clock_i and
  that only single whole-word AHB transfers are made.
*/
`timescale 1ns/10ps
`default_nettype none
module csi_tx_pixel_port
  import csi_tx_pkg::*;
(
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_i,
  // AHB-Lite slave.
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // Video from fabric.
  input wire video_in_t video_i,
  input wire logic frame_format_i,
  input wire logic [1:0] lane_count_i,
  // Sleep requests from fabric.
  input wire sleep_req_t sleep_i,
  // Captured words toward the packetiser.
  output tx_word_t tx_word_o,
  output logic tx_valid_o,
  // Lane pads.
  output logic [4:0] lane_pos_pads_o,
  output logic [4:0] lane_neg_pads_o
);

  typedef struct packed {
    logic strapped;
    logic frame_format;
    logic [1:0] lanes;
    logic frame_sync;
    logic line_sync;
    logic [15:0] width;
    logic [1:0] chan;
    logic [5:0] dtype;
    logic [63:0] word;
    logic word_valid;
    logic [15:0] word_count;
    logic [31:0] clk_tim;
    logic [31:0] dat_tim;
    logic [31:0] rdata;
    logic wr_pend;
    logic [2:0] wr_idx;
    logic clk_phase;
    logic [4:0] pos;
    logic [4:0] neg;
  } port_state_t;

  port_state_t q;
  port_state_t d;

  logic clk_asleep;
  logic [3:0] data_asleep;
  logic frame_rise;
  logic line_rise;
  logic addr_phase;
  logic [2:0] addr_idx;

  // Unmapped addresses decode to an index that reads as zero.
  function automatic logic [2:0] reg_index(input logic [31:0] a);
    logic [2:0] idx;
    idx = a[4:2];
    if ((|a[31:5]) || (a[4:2] > REG_WORDS)) begin
      idx = REG_NONE;
    end
    return idx;
  endfunction : reg_index

  // Lanes enabled by the lane count strap.
  function automatic logic lane_on(input logic [1:0] cnt,
                                   input logic [1:0] lane);
    logic on;
    unique case (cnt)
      LANES_ONE: on = (lane == 2'h0);
      LANES_TWO: on = (lane <= 2'h1);
      LANES_FOUR: on = 1'b1;
      default: on = (lane == 2'h0);
    endcase
    return on;
  endfunction : lane_on

  lane_sleep clk_lane_sleep (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .enter_i(sleep_i.clock_lane_sleep_enter),
    .leave_i(sleep_i.clock_lane_sleep_leave),
    .asleep_o(clk_asleep)
  );

  for (genvar g = 0; g < 4; g++) begin : g_data_sleep
    lane_sleep data_lane_sleep (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .enter_i(sleep_i.data_lane_sleep_enter[g]),
      .leave_i(sleep_i.data_lane_sleep_leave[g]),
      .asleep_o(data_asleep[g])
    );
  end

  assign frame_rise = video_i.frame_sync && !q.frame_sync;
  assign line_rise = video_i.line_sync && !q.line_sync;
  assign addr_phase = hsel_i && htrans_i[1] && hready_i;
  assign addr_idx = reg_index(haddr_i);

  always_comb begin
    logic [2:0] role;
    logic asleep;
    logic enabled;
    logic hs;
    role = 3'h0;
    asleep = 1'b0;
    enabled = 1'b0;
    hs = 1'b0;
    d = q;
    d.frame_sync = video_i.frame_sync;
    d.line_sync = video_i.line_sync;
    d.clk_phase = ~q.clk_phase;

    if (!q.strapped) begin
      d.strapped = 1'b1;
      d.frame_format = frame_format_i;
      d.lanes = lane_count_i;
    end

    // Width and channel are only trusted at the frame start, since the
    // fabric may move them freely while the frame sync is low.
    if (frame_rise) begin
      d.width = video_i.line_width_pixels;
      d.chan = video_i.virtual_channel_id;
    end
    if (line_rise) begin
      d.dtype = video_i.data_type;
      d.word_count = 16'h0000;
    end

    d.word_valid = video_i.valid;
    if (video_i.valid) begin
      d.word = video_i.data;
      d.word_count = 16'(q.word_count + 16'h0001);
      if (line_rise) begin
        d.word_count = 16'h0001;
      end
    end

    // Reads are prepared in the address phase so that the data phase
    // needs no wait state.
    d.wr_pend = addr_phase && hwrite_i;
    d.wr_idx = addr_idx;
    if (addr_phase && !hwrite_i) begin
      unique case (addr_idx)
        REG_CONFIG: begin
          d.rdata = 32'h00000000;
          d.rdata[17:0] = PHY_RATE_SEL;
          d.rdata[CFG_REF_LSB +: 10] = REF_CLK_TABLE[REF_CLK_SEL];
          d.rdata[CFG_CONT_BIT] = CONT_CLOCK;
        end
        REG_CLK_TIM: d.rdata = q.clk_tim;
        REG_DAT_TIM: d.rdata = q.dat_tim;
        REG_STATUS: d.rdata = {22'h0, q.line_sync, q.frame_sync,
                               q.lanes, q.frame_format, data_asleep,
                               clk_asleep};
        REG_LINE: d.rdata = {8'h00, q.chan, q.dtype, q.width};
        REG_WORDS: d.rdata = {16'h0000, q.word_count};
        default: d.rdata = 32'h00000000;
      endcase
    end

    if (q.wr_pend) begin
      if (q.wr_idx == REG_CLK_TIM) begin
        d.clk_tim = hwdata_i;
      end
      if (q.wr_idx == REG_DAT_TIM) begin
        d.dat_tim = {8'h00, hwdata_i[23:0]};
      end
    end

    for (int p = 0; p < 5; p++) begin
      role = LANE_MAP[p];
      if (role == ROLE_CLK) begin
        asleep = clk_asleep;
        enabled = 1'b1;
        hs = CONT_CLOCK || q.frame_sync;
      end else begin
        asleep = data_asleep[2'(role - 3'h1)];
        enabled = lane_on(q.lanes, 2'(role - 3'h1));
        hs = q.line_sync && q.word_valid;
      end
      if (!q.strapped || !enabled || asleep) begin
        d.pos[p] = 1'b0;
        d.neg[p] = 1'b0;
      end else if (!hs) begin
        d.pos[p] = 1'b1;
        d.neg[p] = 1'b1;
      end else if (role == ROLE_CLK) begin
        d.pos[p] = q.clk_phase;
        d.neg[p] = ~q.clk_phase;
      end else begin
        d.pos[p] = q.word[p];
        d.neg[p] = ~q.word[p];
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
      q.clk_tim <= CLK_TIM_RST;
      q.dat_tim <= DAT_TIM_RST;
    end else begin
      q <= d;
    end
  end

  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = q.rdata;
  assign tx_valid_o = q.word_valid;
  assign tx_word_o = '{data: q.word, data_type: q.dtype,
                       virtual_channel_id: q.chan,
                       line_width_pixels: q.width};
  assign lane_pos_pads_o = q.pos;
  assign lane_neg_pads_o = q.neg;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  word_take_a: assert property (
    !video_i.valid |=> !tx_valid_o && $stable(tx_word_o.data))
    else $error("word changed without valid");

  word_pass_a: assert property (
    video_i.valid |=> tx_valid_o && tx_word_o.data == $past(video_i.data))
    else $error("valid word was not captured");

  format_hold_a: assert property (
    q.strapped |=> $stable(q.frame_format))
    else $error("frame format moved outside reset");

  lanes_hold_a: assert property (
    q.strapped |=> $stable(q.lanes))
    else $error("lane count moved outside reset");

  clk_pads_a: assert property (
    clk_asleep |=> lane_pos_pads_o[2] == 1'b0 &&
                   lane_neg_pads_o[2] == 1'b0)
    else $error("sleeping clock lane pads not low");

  clk_wake_a: assert property (
    $fell(clk_asleep) |=> lane_pos_pads_o[2] != lane_neg_pads_o[2] ||
                          lane_pos_pads_o[2])
    else $error("woken clock lane still low");

  lane_off_a: assert property (
    q.strapped && q.lanes == LANES_ONE |=>
      !lane_pos_pads_o[4] && !lane_neg_pads_o[4])
    else $error("disabled data lane is driven");

  timing_write_a: assert property (
    addr_phase && hwrite_i && addr_idx == REG_CLK_TIM ##1 1'b1
    |=> q.clk_tim == $past(hwdata_i))
    else $error("clock timing write lost");

  width_latch_a: assert property (
    frame_rise |=> tx_word_o.line_width_pixels ==
                   $past(video_i.line_width_pixels))
    else $error("line width not caught at frame start");

  chan_latch_a: assert property (
    frame_rise |=> tx_word_o.virtual_channel_id ==
                   $past(video_i.virtual_channel_id))
    else $error("virtual channel not caught at frame start");

  type_latch_a: assert property (
    line_rise |=> tx_word_o.data_type == $past(video_i.data_type))
    else $error("data type not caught at line start");

  count_start_a: assert property (
    line_rise |=> q.word_count == {15'h0, $past(video_i.valid)})
    else $error("word count did not restart at line start");

  strap_catch_a: assert property (
    !q.strapped ##1 q.strapped |-> q.lanes == $past(lane_count_i))
    else $error("lane count not caught after reset");

  dat_write_a: assert property (
    addr_phase && hwrite_i && addr_idx == REG_DAT_TIM ##1 1'b1
    |=> q.dat_tim == {8'h00, $past(hwdata_i[23:0])})
    else $error("data timing write lost");

  timing_read_a: assert property (
    addr_phase && !hwrite_i && addr_idx == REG_CLK_TIM
    |=> hrdata_o == $past(q.clk_tim))
    else $error("clock timing read wrong");

  idle_pads_a: assert property (
    q.strapped && !data_asleep[0] && !(q.line_sync && q.word_valid)
    |=> lane_pos_pads_o[0] && lane_neg_pads_o[0])
    else $error("idle data lane not at stop level");

  clk_toggle_a: assert property (
    !clk_asleep && lane_pos_pads_o[2] != lane_neg_pads_o[2]
    |=> lane_pos_pads_o[2] != $past(lane_pos_pads_o[2]))
    else $error("continuous clock lane stopped");

endmodule : csi_tx_pixel_port
`default_nettype wire

// ### rtl/csi_tx_pkg.sv
/*
  Shared constants, build options and carrier types for the camera
  transmitter pixel input port.
  Assumes one 40 MHz pixel clock and that the build options below are
  fixed when the device is built.
*/
// Function
// - One 64-bit pixel word offered per cycle
// - Frame format chosen, altered only in reset
// - Clock-lane enter pulse puts clock lane asleep
// - Clock-lane leave pulse wakes, pulses 5 us
// - Per-lane enter pulse puts data lane asleep
// - Per-lane leave pulse wakes lane, 5 us
// - Each physical lane mapped at build time
// - Build option: continuous or gated clock lane
// - Line rate selectable from 80 to 1500 MHz
// - Reference clock from a fixed frequency set
// - Lane timing intervals are programmable
// - Lane count decoded, altered only in reset
package csi_tx_pkg;

  // Timing of the sleep request pulses.
  localparam int CLK_PERIOD_NS = 25;
  localparam int ULPS_MIN_NS = 5000;
  localparam int ULPS_MIN_CYC =
    (ULPS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] ULPS_CYC = 8'(ULPS_MIN_CYC);

  // Build options. The line rate is held in units of 10 kHz.
  localparam logic [17:0] PHY_RATE_MIN = 18'h01f40;
  localparam logic [17:0] PHY_RATE_MAX = 18'h249f0;
  localparam logic [17:0] PHY_RATE_SEL = 18'h249f0;
  localparam logic [2:0] REF_CLK_SEL = 3'h2;
  // Reference clock choices in units of 100 kHz, index 7 first.
  localparam logic [7:0][9:0] REF_CLK_TABLE = {
    10'h208, 10'h180, 10'h10e, 10'h104,
    10'h0fa, 10'h0c0, 10'h078, 10'h03c};
  localparam logic CONT_CLOCK = 1'b1;

  // Lane roles and the physical to logical lane map, lane 4 first.
  localparam logic [2:0] ROLE_CLK = 3'h0;
  localparam logic [4:0][2:0] LANE_MAP = {
    3'h4, 3'h3, 3'h0, 3'h2, 3'h1};

  // Register indexes; the byte address is the index times four.
  localparam logic [2:0] REG_CONFIG = 3'h0;
  localparam logic [2:0] REG_CLK_TIM = 3'h1;
  localparam logic [2:0] REG_DAT_TIM = 3'h2;
  localparam logic [2:0] REG_STATUS = 3'h3;
  localparam logic [2:0] REG_LINE = 3'h4;
  localparam logic [2:0] REG_WORDS = 3'h5;
  localparam logic [2:0] REG_NONE = 3'h7;

  // Config register fields.
  localparam int CFG_REF_LSB = 18;
  localparam int CFG_CONT_BIT = 28;

  // Timing register reset values: post, trail, prepare, zero bytes
  // for the clock lane; prepare, zero, trail bytes for data lanes.
  localparam logic [31:0] CLK_TIM_RST = 32'h1c0a0826;
  localparam logic [31:0] DAT_TIM_RST = 32'h000a100a;

  // Lane count encodings.
  localparam logic [1:0] LANES_ONE = 2'h0;
  localparam logic [1:0] LANES_TWO = 2'h1;
  localparam logic [1:0] LANES_FOUR = 2'h3;

  typedef struct packed {
    logic frame_sync;
    logic line_sync;
    logic valid;
    logic [15:0] line_width_pixels;
    logic [5:0] data_type;
    logic [1:0] virtual_channel_id;
    logic [63:0] data;
  } video_in_t;

  typedef struct packed {
    logic clock_lane_sleep_enter;
    logic clock_lane_sleep_leave;
    logic [3:0] data_lane_sleep_enter;
    logic [3:0] data_lane_sleep_leave;
  } sleep_req_t;

  typedef struct packed {
    logic [63:0] data;
    logic [5:0] data_type;
    logic [1:0] virtual_channel_id;
    logic [15:0] line_width_pixels;
  } tx_word_t;

endpackage : csi_tx_pkg

// ### rtl/lane_sleep.sv
/*
  Sleep state of one lane, driven by enter and leave request pulses.
  Assumes the requests come from logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module lane_sleep
  import csi_tx_pkg::*;
(
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_i,
  // Requests.
  input wire logic enter_i,
  input wire logic leave_i,
  // State.
  output logic asleep_o
);

  typedef struct packed {
    logic asleep;
    logic [7:0] cnt;
  } sleep_state_t;

  sleep_state_t q;
  sleep_state_t d;

  // A request acts only once it has stood for the least pulse length,
  // so a glitch on the request line cannot move the lane.
  always_comb begin
    d = q;
    if (enter_i ^ leave_i) begin
      if (q.cnt != ULPS_CYC) begin
        d.cnt = 8'(q.cnt + 8'h01);
      end
      if (q.cnt == ULPS_CYC - 8'h01) begin
        d.asleep = enter_i;
      end
    end else begin
      d.cnt = 8'h00;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign asleep_o = q.asleep;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  enter_sleep_a: assert property (
    (enter_i && !leave_i)[*8] ##0 (q.cnt == ULPS_CYC - 8'h01)
    |=> asleep_o)
    else $error("lane did not sleep after enter pulse");

  leave_wake_a: assert property (
    (leave_i && !enter_i) ##0 (q.cnt == ULPS_CYC - 8'h01)
    |=> !asleep_o)
    else $error("lane did not wake after leave pulse");

  short_pulse_a: assert property (
    !(enter_i ^ leave_i) |=> $stable(asleep_o))
    else $error("lane state moved without a request");

endmodule : lane_sleep
`default_nettype wire
